/* hdl/acsp_pkg.sv */
// Holds the shared constants, command codes, register defaults and types.
// Assumes one master clock for both ends of the link.
//
// What this block does
// - Chip select high aborts, ignores clock, releases output.
// - Chip select high exits standby, resumes continuous readout.
// - Input sampled on rise, output changed on fall.
// - Host keeps data-in low during continuous readout.
// - Sixty-four idle ready periods reset the interface.
// - Sample-ready output is driven at all times.
// - Host finishes reads four clocks before ready falls.
// - Ready rises on first fall; else four-clock pulse.
// - Decode wake, standby, sync, reset ignoring bit zero.
// - Decode start, halt continuous and single read.
// - Register commands: address byte, count byte, data.
// - Trim commands update offset or span registers.
// - Host keeps select low, leaves 24-clock gaps.
// - Standby stops conversions, keeps registers, until woken.
// - Sync cancels read, restarts conversion; host holds pin.
// - Reset restores defaults, restarts, enters continuous readout.
// - Continuous mode presents each result after ready falls.
// - Halt blocks result loading; needed for register access.
// - Halted host sends single read before each result.
// - Register data starts on the 24th falling edge.
// - In continuous mode, results load into the shifter in the same cycle that ready falls.
// - Register write restarts filter; wake restores sync.
// - Configuration bit selects pulse or continuous sync.

package acsp_pkg;
    // ==========================================================
    // Timing
    localparam logic [4:0] GAP_CYCLES = 5'h18;
    localparam logic [2:0] SAMPLE_READY_N_PULSE_CYCLES = 3'h4;
    localparam logic [6:0] TIMEOUT_LAST = 7'h3F;
    localparam logic [4:0] SCLK_HALF = 5'h10;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [15:0] DATA_PERIOD_DEFAULT = 16'h07D0;

    // ==========================================================
    // Command codes
    localparam logic [7:0] CTRL_MASK = 8'hFE;
    localparam logic [7:0] OP_WAKE = 8'h00;
    localparam logic [7:0] OP_STANDBY = 8'h02;
    localparam logic [7:0] OP_SYNC = 8'h04;
    localparam logic [7:0] OP_RESET = 8'h06;
    localparam logic [7:0] OP_CONT = 8'h10;
    localparam logic [7:0] OP_HALT = 8'h11;
    localparam logic [7:0] OP_SINGLE = 8'h12;
    localparam logic [7:0] OP_ZERO_TRIM = 8'h60;
    localparam logic [7:0] OP_SPAN_TRIM = 8'h61;
    localparam logic [2:0] PFX_READ = 3'h1;
    localparam logic [2:0] PFX_WRITE = 3'h2;
    localparam logic [2:0] PFX_COUNT = 3'h0;

    // ==========================================================
    // Device registers
    localparam logic [3:0] ID_CODE = 4'hA; // Arbitrary identity value.
    localparam logic [4:0] REG_IDCFG = 5'h00;
    localparam logic [4:0] REG_CONFIG0 = 5'h01;
    localparam logic [4:0] REG_OFFSET0 = 5'h05;
    localparam logic [4:0] REG_SPAN0 = 5'h08;
    localparam int SYNC_MODE_BIT = 7;
    localparam logic [31:0][7:0] REG_DEFAULTS = {{21{8'h00}}, 8'h40, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h03, 8'h32, 8'h08, 8'h52, ID_CODE, 4'h0};

    // ==========================================================
    // Host APB registers
    localparam logic [11:0] HREG_CTRL = 12'h000;
    localparam logic [11:0] HREG_TX = 12'h004;
    localparam logic [11:0] HREG_RX = 12'h008;
    localparam int TX_NOGAP_BIT = 8;
    localparam int RX_BUSY_BIT = 8;
    localparam int RX_READY_BIT = 9;

    typedef enum logic [3:0] {
        CMD_NONE, CMD_WAKE, CMD_STANDBY, CMD_SYNC, CMD_RESET, CMD_CONT, CMD_HALT,
        CMD_SINGLE, CMD_REGISTER_READ_CMD, CMD_REGISTER_WRITE_CMD, CMD_ZERO, CMD_SPAN
    } acsp_cmd_type;

    typedef enum logic [2:0] {
        ST_CMD = 3'h0, ST_ARG = 3'h1, ST_RWAIT = 3'h3, ST_RDOUT = 3'h2, ST_WDATA = 3'h5
    } acsp_state_type;
endpackage

/* hdl/acsp_link_if.sv */
// Four-wire serial link plus sample-ready, host to device.
// Assumes a weak pull-up on the data-out wire while the device releases it.
`timescale 1ns/1ps
interface acsp_link_if;
    logic csN;
    logic sclk;
    logic din;
    logic dout;
    logic doutOe;
    logic sampleReadyN;
    logic doutLine;

    // ==========================================================
    // Wire level of data-out, resolved from the enable.
    assign doutLine = doutOe ? dout : 1'b1;

    modport device (input csN, input sclk, input din, output dout, output doutOe,
        output sampleReadyN);
    modport host (output csN, output sclk, output din, input doutLine,
        input sampleReadyN);
endinterface

/* hdl/acsp_device.sv */
// Holds the converter-side serial command port with its register bytes.
// Assumes asynchronous link pins and results from a filter.
//
// Design decisions made here: the placing of the registers.
`timescale 1ns/1ps
module acsp_device
    import acsp_pkg::*;
#(
    parameter logic [15:0] DATA_PERIOD_CYCLES = DATA_PERIOD_DEFAULT
) (
    input wire logic clk,
    input wire logic arst_n,
    acsp_link_if.device link,
    input wire logic [31:0] convData,
    input wire logic calDone,
    input wire logic [23:0] calWord,
    output logic standbyOn,
    output logic convRestart,
    output logic calStart,
    output logic calGain,
    output logic syncCont
);
    localparam logic [15:0] PER_LAST = DATA_PERIOD_CYCLES - 16'h0001;

    typedef struct packed {
        logic [2:0] csS;
        logic [2:0] sckS;
        logic [2:0] dinS;
        logic csF;
        logic sckF;
        logic dinF;
        acsp_state_type st;
        logic [2:0] bitCnt;
        logic [6:0] rxSh;
        logic [31:0] txSh;
        logic [2:0] txCnt;
        logic [4:0] addr;
        logic [4:0] cnt;
        logic rdOp;
        logic contMode;
        logic standby;
        logic [15:0] perCnt;
        logic [2:0] pulseCnt;
        logic drdyN;
        logic [6:0] toCnt;
        logic [31:0] result;
        logic dout;
        logic oe;
        logic restart;
        logic calGo;
        logic calSpan;
        logic [31:0][7:0] regs;
    } acsp_dev_type;

    acsp_dev_type q_r;
    acsp_dev_type q_nxt;

    // ==========================================================
    // Command decoder for an opcode byte.
    function automatic acsp_cmd_type decode(input logic [7:0] b);
        acsp_cmd_type c;
        c = CMD_NONE;
        if ((b & CTRL_MASK) == OP_WAKE) c = CMD_WAKE;
        else if ((b & CTRL_MASK) == OP_STANDBY) c = CMD_STANDBY;
        else if ((b & CTRL_MASK) == OP_SYNC) c = CMD_SYNC;
        else if ((b & CTRL_MASK) == OP_RESET) c = CMD_RESET;
        else if (b == OP_CONT) c = CMD_CONT;
        else if (b == OP_HALT) c = CMD_HALT;
        else if (b == OP_SINGLE) c = CMD_SINGLE;
        else if (b == OP_ZERO_TRIM) c = CMD_ZERO;
        else if (b == OP_SPAN_TRIM) c = CMD_SPAN;
        else if (b[7:5] == PFX_READ) c = CMD_REGISTER_READ_CMD;
        else if (b[7:5] == PFX_WRITE) c = CMD_REGISTER_WRITE_CMD;
        return c;
    endfunction

    logic rise;
    logic fall;
    logic byteDone;
    logic [7:0] rxByte;
    logic [4:0] base;

    // ==========================================================
    // Next-state logic of the whole port.
    always_comb begin
        q_nxt = q_r;
        q_nxt.restart = 1'b0;
        q_nxt.calGo = 1'b0;
        // Three-stage synchronisers; stages two and three must agree.
        q_nxt.csS = {q_r.csS[1:0], link.csN};
        q_nxt.sckS = {q_r.sckS[1:0], link.sclk};
        q_nxt.dinS = {q_r.dinS[1:0], link.din};
        if (q_r.csS[1] == q_r.csS[2]) q_nxt.csF = q_r.csS[2];
        if (q_r.sckS[1] == q_r.sckS[2]) q_nxt.sckF = q_r.sckS[2];
        if (q_r.dinS[1] == q_r.dinS[2]) q_nxt.dinF = q_r.dinS[2];
        rise = q_nxt.sckF & ~q_r.sckF & ~q_nxt.csF;
        fall = ~q_nxt.sckF & q_r.sckF & ~q_nxt.csF;
        byteDone = rise && (q_r.bitCnt == BIT_LAST);
        rxByte = {q_r.rxSh, q_nxt.dinF};
        base = REG_OFFSET0;

        // Conversion period and four-clock ready pulse.
        if (!q_r.standby) begin
            if (q_r.perCnt == PER_LAST) begin
                q_nxt.perCnt = 16'h0000;
                q_nxt.result = convData;
                q_nxt.drdyN = 1'b1;
                q_nxt.pulseCnt = SAMPLE_READY_N_PULSE_CYCLES;
            end else begin
                q_nxt.perCnt = q_r.perCnt + 16'h0001;
            end
        end
        if (q_r.pulseCnt != 3'h0) begin
            q_nxt.pulseCnt = q_r.pulseCnt - 3'h1;
            if (q_r.pulseCnt == 3'h1) begin
                q_nxt.drdyN = 1'b0;
                // New result loads as ready falls.
                if (q_r.contMode) q_nxt.txSh = q_nxt.result;
                // Idle selected clock counts ready periods to a timeout.
                if (!q_r.csF && !q_r.sckF) begin
                    q_nxt.toCnt = q_r.toCnt + 7'h01;
                    if (q_r.toCnt == TIMEOUT_LAST) begin
                        q_nxt.toCnt = 7'h00;
                        q_nxt.st = ST_CMD;
                        q_nxt.bitCnt = 3'h0;
                    end
                end
            end
        end
        if (fall && !q_r.drdyN) q_nxt.drdyN = 1'b1;

        // Bit capture on each rising clock edge.
        if (rise) begin
            q_nxt.bitCnt = q_r.bitCnt + 3'h1;
            q_nxt.rxSh = rxByte[6:0];
            q_nxt.toCnt = 7'h00;
        end

        // Byte handling per parser state.
        if (byteDone) begin
            case (q_r.st)
                ST_CMD: begin
                    case (decode(rxByte))
                        CMD_WAKE: begin
                            q_nxt.standby = 1'b0;
                            q_nxt.restart = q_r.standby;
                        end
                        CMD_STANDBY: q_nxt.standby = 1'b1;
                        CMD_SYNC: begin
                            q_nxt.txSh = 32'h00000000;
                            q_nxt.perCnt = 16'h0000;
                            q_nxt.pulseCnt = 3'h0;
                            q_nxt.restart = 1'b1;
                        end
                        CMD_RESET: begin
                            q_nxt.regs = REG_DEFAULTS;
                            q_nxt.contMode = 1'b1;
                            q_nxt.standby = 1'b0;
                            q_nxt.perCnt = 16'h0000;
                            q_nxt.pulseCnt = 3'h0;
                            q_nxt.restart = 1'b1;
                        end
                        CMD_CONT: q_nxt.contMode = 1'b1;
                        CMD_HALT: q_nxt.contMode = 1'b0;
                        CMD_SINGLE: q_nxt.txSh = q_r.result;
                        CMD_REGISTER_READ_CMD, CMD_REGISTER_WRITE_CMD: begin
                            // Register access only while readout is halted.
                            if (!q_r.contMode) begin
                                q_nxt.addr = rxByte[4:0];
                                q_nxt.rdOp = (rxByte[7:5] == PFX_READ);
                                q_nxt.st = ST_ARG;
                            end
                        end
                        CMD_ZERO, CMD_SPAN: begin
                            q_nxt.calGo = 1'b1;
                            q_nxt.calSpan = rxByte[0];
                        end
                        default: ;
                    endcase
                end
                ST_ARG: begin
                    q_nxt.cnt = rxByte[4:0];
                    if (rxByte[7:5] != PFX_COUNT) q_nxt.st = ST_CMD;
                    else q_nxt.st = q_r.rdOp ? ST_RWAIT : ST_WDATA;
                end
                ST_WDATA: begin
                    q_nxt.regs[q_r.addr] = rxByte;
                    if (q_r.addr == REG_IDCFG) q_nxt.regs[REG_IDCFG] = {ID_CODE, rxByte[3:0]};
                    q_nxt.addr = q_r.addr + 5'h01;
                    q_nxt.cnt = q_r.cnt - 5'h01;
                    if (q_r.cnt == 5'h00) begin
                        q_nxt.st = ST_CMD;
                        q_nxt.perCnt = 16'h0000;
                        q_nxt.pulseCnt = 3'h0;
                        q_nxt.restart = 1'b1;
                    end
                end
                ST_RWAIT: begin
                    q_nxt.st = ST_RDOUT;
                    q_nxt.txCnt = BIT_LAST;
                end
                ST_RDOUT: begin
                    q_nxt.cnt = q_r.cnt - 5'h01;
                    if (q_r.cnt == 5'h00) q_nxt.st = ST_CMD;
                end
                default: q_nxt.st = ST_CMD;
            endcase
        end

        // Output shifting on each falling clock edge.
        if (fall) begin
            if (q_r.st == ST_RDOUT && q_r.txCnt == BIT_LAST) begin
                q_nxt.txSh = {q_r.regs[q_r.addr], 24'h000000};
                q_nxt.addr = q_r.addr + 5'h01;
                q_nxt.txCnt = 3'h0;
            end else begin
                q_nxt.txSh = {q_r.txSh[30:0], 1'b0};
                q_nxt.txCnt = q_r.txCnt + 3'h1;
            end
        end

        // Calibration result lands in offset or span bytes.
        if (calDone) begin
            base = q_r.calSpan ? REG_SPAN0 : REG_OFFSET0;
            q_nxt.regs[base] = calWord[7:0];
            q_nxt.regs[base + 5'h01] = calWord[15:8];
            q_nxt.regs[base + 5'h02] = calWord[23:16];
        end

        // Deselect aborts and resumes continuous readout.
        if (q_nxt.csF) begin
            q_nxt.st = ST_CMD;
            q_nxt.bitCnt = 3'h0;
            q_nxt.toCnt = 7'h00;
            q_nxt.contMode = 1'b1;
            q_nxt.standby = 1'b0;
        end
        q_nxt.oe = ~q_nxt.csF;
        q_nxt.dout = q_nxt.txSh[31];
    end

    // ==========================================================
    // State register.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q_r <= '0;
            q_r.csS <= 3'h7;
            q_r.csF <= 1'b1;
            q_r.contMode <= 1'b1;
            q_r.drdyN <= 1'b1;
            q_r.regs <= REG_DEFAULTS;
        end else begin
            q_r <= q_nxt;
        end
    end

    // ==========================================================
    // Outputs straight from the state register.
    assign link.dout = q_r.dout;
    assign link.doutOe = q_r.oe;
    assign link.sampleReadyN = q_r.drdyN;
    assign standbyOn = q_r.standby;
    assign convRestart = q_r.restart;
    assign calStart = q_r.calGo;
    assign calGain = q_r.calSpan;
    assign syncCont = q_r.regs[REG_CONFIG0][SYNC_MODE_BIT];
endmodule

/* hdl/acsp_host.sv */
// Holds the host-side serial controller, driven by software over APB.
// Assumes software sequences commands.
`timescale 1ns/1ps
module acsp_host
    import acsp_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    acsp_link_if.host link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic csWant;
        logic csN;
        logic sclk;
        logic din;
        logic busy;
        logic noGap;
        logic [7:0] txSh;
        logic [7:0] rxSh;
        logic [2:0] bitCnt;
        logic [4:0] halfCnt;
        logic [4:0] gapCnt;
        logic [2:0] doutS;
        logic doutF;
        logic [2:0] rdyS;
        logic rdyF;
    } acsp_host_type;

    acsp_host_type h_r;
    acsp_host_type h_nxt;
    logic wrAcc;

    // ==========================================================
    // Next-state logic: APB slave, byte shifter and gap timer.
    always_comb begin
        h_nxt = h_r;
        wrAcc = psel & penable & h_r.pready & pwrite;
        h_nxt.doutS = {h_r.doutS[1:0], link.doutLine};
        h_nxt.rdyS = {h_r.rdyS[1:0], link.sampleReadyN};
        if (h_r.doutS[1] == h_r.doutS[2]) h_nxt.doutF = h_r.doutS[2];
        if (h_r.rdyS[1] == h_r.rdyS[2]) h_nxt.rdyF = h_r.rdyS[2];
        if (h_r.gapCnt != 5'h00) h_nxt.gapCnt = h_r.gapCnt - 5'h01;

        // One-cycle answer in the access phase.
        h_nxt.pready = psel & ~penable;
        h_nxt.pslverr = 1'b0;
        h_nxt.prdata = 32'h00000000;
        if (psel && !penable) begin
            case (paddr)
                HREG_CTRL: h_nxt.prdata = {31'h0, h_r.csWant};
                HREG_TX: h_nxt.prdata = {24'h0, h_r.txSh};
                HREG_RX: h_nxt.prdata = {22'h0, h_r.rdyF, h_r.busy, h_r.rxSh};
                default: h_nxt.pslverr = 1'b1;
            endcase
        end
        if (wrAcc && paddr == HREG_CTRL) h_nxt.csWant = pwdata[0];
        // A byte starts with select low, shifter idle, gap spent.
        if (wrAcc && paddr == HREG_TX && !h_r.busy && !h_r.csN && h_r.gapCnt == 5'h00) begin
            h_nxt.busy = 1'b1;
            h_nxt.txSh = pwdata[7:0];
            h_nxt.noGap = pwdata[TX_NOGAP_BIT];
            h_nxt.din = pwdata[7];
            h_nxt.bitCnt = 3'h0;
            h_nxt.halfCnt = SCLK_HALF;
        end

        // Clock divider: data set while low, data-out taken on the rise.
        if (h_r.busy) begin
            h_nxt.halfCnt = h_r.halfCnt - 5'h01;
            if (h_r.halfCnt == 5'h00) begin
                h_nxt.halfCnt = SCLK_HALF;
                h_nxt.sclk = ~h_r.sclk;
                if (!h_r.sclk) begin
                    h_nxt.rxSh = {h_r.rxSh[6:0], h_r.doutF};
                    if (h_r.bitCnt == BIT_LAST && !h_r.noGap) h_nxt.gapCnt = GAP_CYCLES;
                end else if (h_r.bitCnt == BIT_LAST) begin
                    h_nxt.busy = 1'b0;
                    h_nxt.din = 1'b0;
                end else begin
                    h_nxt.bitCnt = h_r.bitCnt + 3'h1;
                    h_nxt.din = h_r.txSh[3'h6 - h_r.bitCnt];
                end
            end
        end

        // Select follows software, never inside a byte or gap.
        if (!h_r.busy && h_r.gapCnt == 5'h00) h_nxt.csN = ~h_r.csWant;
    end

    // ==========================================================
    // State register.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            h_r <= '0;
            h_r.csN <= 1'b1;
            h_r.doutS <= 3'h7;
            h_r.doutF <= 1'b1;
            h_r.rdyS <= 3'h7;
            h_r.rdyF <= 1'b1;
        end else begin
            h_r <= h_nxt;
        end
    end

    // ==========================================================
    // Outputs straight from the state register.
    assign link.csN = h_r.csN;
    assign link.sclk = h_r.sclk;
    assign link.din = h_r.din;
    assign prdata = h_r.prdata;
    assign pready = h_r.pready;
    assign pslverr = h_r.pslverr;
endmodule

/* testbench/acsp_link_checker.sv */
// Concurrent checks on the serial link between the two ends.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/1ps
module acsp_link_checker (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic csN,
    input wire logic sclk,
    input wire logic din,
    input wire logic doutOe,
    input wire logic sampleReadyN
);
    logic sclkQ_r;
    logic [7:0] riseGap_r;
    logic [7:0] lowCnt_r;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // ==========================================================
    // Helpers
    // Counts cycles since the last sclk rise and while sclk is low.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sclkQ_r <= 1'h0;
            riseGap_r <= 8'hFF;
            lowCnt_r <= 8'hFF;
        end else begin
            sclkQ_r <= sclk;
            riseGap_r <= (sclk && !sclkQ_r) ? 8'h00 : riseGap_r + 8'(riseGap_r != 8'hFF);
            lowCnt_r <= sclk ? 8'h00 : lowCnt_r + 8'(lowCnt_r != 8'hFF);
        end
    end

    // ==========================================================
    // Assertions
    // The checks on device outputs allow for the input filter delay of the device.
    property p_release_cs_high; csN [*8] |-> !doutOe; endproperty
    a_release_cs_high: assert property (p_release_cs_high)
        else $error("data-out driven while deselected");
    property p_enable_cs_low; $rose(doutOe) |-> !csN && !$past(csN, 3); endproperty
    a_enable_cs_low: assert property (p_enable_cs_low)
        else $error("data-out enabled without select");
    property p_sclk_idle_low; csN |-> !sclk; endproperty
    a_sclk_idle_low: assert property (p_sclk_idle_low)
        else $error("sclk high while idle");
    property p_din_stable_high; sclk && $past(sclk) |-> $stable(din); endproperty
    a_din_stable_high: assert property (p_din_stable_high)
        else $error("din moved while sclk high");
    property p_cs_fall_quiet; $fell(csN) |-> !sclk [*8]; endproperty
    a_cs_fall_quiet: assert property (p_cs_fall_quiet)
        else $error("sclk active too soon after select");
    property p_rise_spacing; $rose(sclk) |-> riseGap_r >= 8'h17; endproperty
    a_rise_spacing: assert property (p_rise_spacing)
        else $error("sclk rises too close");
    property p_cs_rise_gap; $rose(csN) |-> riseGap_r >= 8'h17; endproperty
    a_cs_rise_gap: assert property (p_cs_rise_gap)
        else $error("select raised too soon after a byte");
    property p_ready_pulse; $rose(sampleReadyN) && lowCnt_r > 8'h14 |-> sampleReadyN [*4];
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("sample-ready pulse shorter than four cycles");
    property p_ready_on_fall; $fell(sclk) && !csN |-> ##[1:8] sampleReadyN; endproperty
    a_ready_on_fall: assert property (p_ready_on_fall)
        else $error("sample-ready not raised by sclk fall");

    // Main scenarios reached.
    c_ready_fall: cover property ($fell(sampleReadyN) && !csN);
    c_cs_rise: cover property ($rose(csN));
    c_drive: cover property ($rose(doutOe));
endmodule

/* testbench/tb.sv */
// Bench top: APB drives the host end, which talks to the device end.
// Assumes design files and checker are compiled first.
`timescale 1ns/1ps
module tb
    import acsp_pkg::*;
;
    logic clk = 1'h0, arst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, convData = 32'h0, prdata, q, d, seed;
    logic calDone = 1'h0, pready, pslverr, e;
    logic [23:0] calWord = 24'h0;
    logic standbyOn, convRestart, calStart, calGain, syncCont;
    logic [7:0] rx;
    logic [7:0] shadow [0:31];
    logic [4:0] a;
    int nErrors = 0, checkCount = 0, nRestart = 0, nCal = 0, r0, n;

    acsp_link_if link();
    acsp_host i_acsp_host (.clk(clk), .arst_n(arst_n), .link(link), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    acsp_device i_acsp_device (.clk(clk), .arst_n(arst_n), .link(link),
        .convData(convData), .calDone(calDone), .calWord(calWord), .standbyOn(standbyOn),
        .convRestart(convRestart), .calStart(calStart), .calGain(calGain),
        .syncCont(syncCont));
    acsp_link_checker i_chk (.clk(clk), .arst_n(arst_n), .csN(link.csN), .sclk(link.sclk),
        .din(link.din), .doutOe(link.doutOe), .sampleReadyN(link.sampleReadyN));

    // 200 MHz clock.
    initial begin
        forever #2.5 clk = ~clk;
    end

    // Counts restart and trim pulses of the device.
    always @(posedge clk) begin
        nRestart <= nRestart + int'(convRestart === 1'h1);
        nCal <= nCal + int'(calStart === 1'h1);
    end

    // ==========================================================
    // Tasks
    // Compares seen against expected.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checkCount++;
        if (seen !== exp) begin
            nErrors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // One clock of a bounded wait.
    task automatic tick(inout int k);
        @(posedge clk);
        k++;
        if (k > 6000) begin
            nErrors++;
            report_and_stop();
        end
    endtask

    // One APB transfer; the answer lands in q and e.
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
        int k;
        k = 0;
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'h1;
        do tick(k); while (pready !== 1'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask

    // Sends a byte; the byte received lands in rx.
    task automatic xfer(input logic [7:0] b, input logic fast);
        int k;
        k = 0;
        apb(1'h1, HREG_TX, {23'h0, fast, b});
        repeat (4) @(posedge clk);
        do begin
            apb(1'h0, HREG_RX, 32'h0);
            tick(k);
        end while (q[RX_BUSY_BIT] !== 1'h0);
        rx = q[7:0];
        repeat (30) @(posedge clk);
    endtask

    // Reads cnt+1 registers from ra against the shadow.
    task automatic rdregs(input logic [4:0] ra, input int cnt);
        xfer({PFX_READ, ra}, 1'h0);
        xfer(8'(cnt), 1'h0);
        xfer(8'h00, 1'h0);
        for (int i = 0; i <= cnt; i++) begin
            xfer(8'h00, 1'h0);
            check(rx, shadow[ra + i]);
        end
    endtask

    // Writes cnt+1 random bytes from wa into the shadow.
    task automatic wrregs(input logic [4:0] wa, input int cnt);
        xfer({PFX_WRITE, wa}, 1'h0);
        xfer(8'(cnt), 1'h0);
        for (int i = 0; i <= cnt; i++) begin
            shadow[wa + i] = 8'($random(seed));
            xfer(shadow[wa + i], 1'h0);
        end
    endtask

    // Waits for a falling edge of sample-ready.
    task automatic wait_ready();
        int k;
        k = 0;
        while (link.sampleReadyN !== 1'h1) tick(k);
        while (link.sampleReadyN !== 1'h0) tick(k);
    endtask

    // Clocks out a random result with din low.
    task automatic conv_read();
        wait_ready();
        d = $random(seed);
        convData <= d;
        wait_ready();
        for (int i = 0; i < 4; i++) begin
            xfer(8'h00, 1'h1);
            check(rx, d[31 - 8 * i -: 8]);
        end
    endtask

    // Prints counts and verdict, then ends the run.
    task automatic report_and_stop();
        $display("Checks %0d, errors %0d", checkCount, nErrors);
        if (nErrors == 0 && checkCount > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        seed = 32'h13A51A57;
        for (int i = 0; i < 32; i++) shadow[i] = REG_DEFAULTS[i];
        repeat (16) @(posedge clk);
        arst_n <= 1'h1;
        @(posedge clk);
        check(8'(link.doutOe), 8'h0);
        apb(1'h0, 12'h00C, 32'h0);
        check(8'(e), 8'h1);
        check(q[7:0], 8'h00);
        apb(1'h1, HREG_CTRL, 32'h1);
        repeat (2) conv_read();
        xfer(OP_HALT, 1'h0);
        rdregs(5'h01, 9);
        repeat (4) begin
            a = 5'(1 + $unsigned($random(seed)) % 8);
            n = $unsigned($random(seed)) % 3;
            r0 = nRestart;
            wrregs(a, n);
            check(8'(nRestart - r0), 8'h01);
            check(8'(syncCont), 8'(shadow[1][7]));
            rdregs(a, n);
        end
        xfer(8'h13, 1'h0);
        check(8'(standbyOn), 8'h0);
        rdregs(5'h01, 0);
        for (int i = 0; i < 2; i++) begin
            xfer(OP_STANDBY | 8'(i), 1'h0);
            check(8'(standbyOn), 8'h1);
            r0 = nRestart;
            xfer(OP_WAKE | 8'(i), 1'h0);
            check(8'(standbyOn), 8'h0);
            xfer(OP_SYNC | 8'(i), 1'h0);
            check(8'(nRestart - r0), 8'h02);
            r0 = nCal;
            xfer(OP_ZERO_TRIM | 8'(i), 1'h0);
            check(8'(nCal - r0), 8'h01);
            check(8'(calGain), 8'(i));
            d = $random(seed);
            calWord <= d[23:0];
            calDone <= 1'h1;
            @(posedge clk);
            calDone <= 1'h0;
            a = i ? REG_SPAN0 : REG_OFFSET0;
            for (int k = 0; k < 3; k++) shadow[a + k] = d[8 * k +: 8];
            rdregs(a, 2);
        end
        xfer(OP_RESET | 8'h01, 1'h0);
        for (int i = 0; i < 32; i++) shadow[i] = REG_DEFAULTS[i];
        xfer(OP_HALT, 1'h0);
        rdregs(5'h01, 9);
        xfer(OP_CONT, 1'h0);
        conv_read();
        xfer(OP_HALT, 1'h0);
        xfer(OP_STANDBY, 1'h0);
        apb(1'h1, HREG_CTRL, 32'h0);
        repeat (20) @(posedge clk);
        check(8'(standbyOn), 8'h0);
        check(8'(link.doutOe), 8'h0);
        apb(1'h1, HREG_CTRL, 32'h1);
        conv_read();
        report_and_stop();
    end
endmodule
